// >>> bus_pin_pkg.sv
// Package: offsets, field layouts and reset values for the status pin block
package bus_pin_pkg;

  // ----------------------------------------------------------------
  // Status control register
  // ----------------------------------------------------------------
  localparam logic [11:0] STAT_CTRL_OFFSET = 12'h262; // Word address
  localparam int DRV_A_LSB = 0;       // Pin a drive type field
  localparam int SEL_A_LSB = 2;       // Pin a condition select field
  localparam int LVL_A_BIT = 5;       // Pin a level readback
  localparam int DRV_B_LSB = 8;       // Pin b drive type field
  localparam int SEL_B_LSB = 10;      // Pin b condition select field
  localparam int LVL_B_BIT = 13;      // Pin b level readback
  localparam logic [1:0] DRV_RESET = 2'h2;  // Drive field reset value
  localparam logic [2:0] SEL_RESET = 3'h0;  // Select field reset value

  // Drive type codes
  localparam logic [1:0] DRV_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] DRV_PUSH_PULL = 2'h2;

  // ----------------------------------------------------------------
  // Configuration memory map
  // ----------------------------------------------------------------
  localparam int OTP_WORDS = 32;      // Locations 0x00 to 0x1f
  localparam int OTP_AW = 5;          // Address width
  localparam int OTP_DW = 8;          // Every location is one byte
  localparam logic [7:0] OTP_RESET = 8'h00; // Unprogrammed value
  localparam logic [4:0] OTP_HW_LOCK_CFG = 5'h00;
  localparam int LOCK_BIT = 6;        // Global write lock position
  localparam logic [4:0] OTP_OVR_FIRST = 5'h07; // Class override span
  localparam logic [4:0] OTP_OVR_LAST = 5'h11;
  localparam logic [4:0] OTP_VENDOR_LOW = 5'h12;
  localparam logic [4:0] OTP_VENDOR_HIGH = 5'h13;
  localparam logic [4:0] OTP_PRODUCT_LOW = 5'h14;
  localparam logic [4:0] OTP_PRODUCT_HIGH = 5'h15;
  localparam logic [4:0] OTP_POWER_BUDGET = 5'h16;
  localparam logic [4:0] OTP_WAKE_ATTRS = 5'h17;
  localparam logic [4:0] OTP_RELEASE_HIGH = 5'h18;
  localparam logic [4:0] OTP_RELEASE_LOW = 5'h19;
  localparam logic [4:0] OTP_PURGE = 5'h1a;
  localparam logic [4:0] OTP_COMMIT_A = 5'h1d;
  localparam logic [4:0] OTP_COMMIT_B = 5'h1e;

  // Commit bit positions in the 16-bit commit word {b, a}
  localparam int CB_VENDOR = 8;
  localparam int CB_PRODUCT = 9;
  localparam int CB_POWER = 10;
  localparam int CB_ATTRS = 11;
  localparam int CB_RELEASE = 12;
  localparam int CB_PURGE = 13;
  localparam int CB_NONE = 16;        // Location has no commit bit

  // Power budget above this (units of 2 mA) means high power
  localparam logic [7:0] LOW_POWER_MAX = 8'h32;

endpackage : bus_pin_pkg

// >>> bus_pin_cond.sv
// One status pin: condition decode, polarity and drive type
module bus_pin_cond
#(
  parameter bit PIN_B = 1'b0          // Selects the code-000/100 polarity
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Field settings
  input wire logic [2:0] i_sel,
  input wire logic [1:0] i_drive,
  // Bus state
  input wire logic i_suspend,
  input wire logic i_bus_reset,
  input wire logic i_configured,
  input wire logic i_high_power,
  // Pin drive
  output logic o_pin,
  output logic o_pin_oe
);
  import bus_pin_pkg::*;

  logic cond;       // Selected condition is present
  logic act_high;   // Asserted level of the pin
  logic level;      // Level the pin should show

  // ----------------------------------------------------------------
  // Condition decode, shared by both halves of the select code
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (i_sel[1:0])
      2'h0: cond = i_suspend | i_bus_reset;
      2'h1: cond = i_suspend;
      // Low power: suspend only; high power adds unconfigured
      2'h2: cond = i_suspend | (i_high_power & ~i_configured);
      default: cond = i_bus_reset;
    endcase
  end

  // Pin a asserts low on 000; pin b asserts high on 100
  assign act_high = PIN_B ? (i_sel != 3'h5 && i_sel != 3'h6 &&
                             i_sel != 3'h7)
                          : (i_sel != 3'h0 && !i_sel[2]);
  assign level = cond ? act_high : ~act_high;

  // ----------------------------------------------------------------
  // Registered drive, one clock after any input change
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      // Released until the first decode
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
    end
    else if (i_drive == DRV_PUSH_PULL)
    begin
      o_pin <= level;
      o_pin_oe <= 1'b1;
    end
    else if (i_drive == DRV_OPEN_DRAIN)
    begin
      // Only ever pulls low; high comes from the pull-up
      o_pin <= 1'b0;
      o_pin_oe <= ~level;
    end
    else
    begin
      // Invalid drive codes leave the pin released
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
    end
  end

endmodule : bus_pin_cond

// >>> bus_pin_otp_top.sv
// Top: status pin control register and one-time configuration memory
module bus_pin_otp_top
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  // Register port
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [11:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  output logic [15:0] O_REG_RDATA,
  // Configuration memory port
  input wire logic I_OTP_PROG,
  input wire logic I_OTP_RD,
  input wire logic [bus_pin_pkg::OTP_AW-1:0] I_OTP_ADDR,
  input wire logic [bus_pin_pkg::OTP_DW-1:0] I_OTP_WDATA,
  output logic [bus_pin_pkg::OTP_DW-1:0] O_OTP_RDATA,
  output logic O_OTP_REFUSED,
  // Bus state from the device core
  input wire logic I_SUSPEND,
  input wire logic I_BUS_RESET,
  input wire logic I_CONFIGURED,
  // Status pins
  input wire logic I_PIN_A,
  output logic O_PIN_A,
  output logic O_PIN_A_OE,
  input wire logic I_PIN_B,
  output logic O_PIN_B,
  output logic O_PIN_B_OE,
  // Effective configuration
  output logic [15:0] O_VENDOR_CODE,
  output logic [15:0] O_PRODUCT_CODE,
  output logic O_HIGH_POWER
);
  import bus_pin_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] pin_a_drive_type;        // Pin a drive field
  logic [2:0] pin_a_condition_select;  // Pin a condition field
  logic [1:0] pin_b_drive_type;        // Pin b drive field
  logic [2:0] pin_b_condition_select;  // Pin b condition field
  logic [2:0] sync_a;                  // Pin a input synchroniser
  logic [2:0] sync_b;                  // Pin b input synchroniser
  logic pin_a_level_readback;          // Filtered pin a level
  logic pin_b_level_readback;          // Filtered pin b level
  logic [OTP_DW-1:0] otp_mem [OTP_WORDS]; // Memory array
  logic otp_global_write_lock;         // Lock bit of location 0
  logic [15:0] commit;                 // Both commit bytes
  logic [7:0] field_commit_bits_low;   // Commit byte a
  logic [7:0] field_commit_bits_high;  // Commit byte b
  logic prog_ok;                       // Programming accepted
  logic [4:0] prog_field;              // Commit index of target
  logic [15:0] stat_word;              // Status register image
  logic [7:0] eff_power;               // Effective power budget
  logic high_power;                    // Device draws over 100 mA

  // ----------------------------------------------------------------
  // Status control register writes
  // ----------------------------------------------------------------
  // Reserved and readback bits are simply not stored
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      pin_a_drive_type <= DRV_RESET;
      pin_b_drive_type <= DRV_RESET;
      pin_a_condition_select <= SEL_RESET;
      pin_b_condition_select <= SEL_RESET;
    end
    else if (I_REG_WR && I_REG_ADDR == STAT_CTRL_OFFSET)
    begin
      // Bits 7:6 dropped whatever software writes
      pin_a_drive_type <= I_REG_WDATA[DRV_A_LSB +: 2];
      pin_a_condition_select <= I_REG_WDATA[SEL_A_LSB +: 3];
      pin_b_drive_type <= I_REG_WDATA[DRV_B_LSB +: 2];
      pin_b_condition_select <= I_REG_WDATA[SEL_B_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Pin level readback
  // ----------------------------------------------------------------
  // Three stages; the level moves once stages two and three agree
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      pin_a_level_readback <= 1'b0;
      pin_b_level_readback <= 1'b0;
    end
    else
    begin
      sync_a <= {sync_a[1:0], I_PIN_A};
      sync_b <= {sync_b[1:0], I_PIN_B};
      if (sync_a[1] == sync_a[2])
      begin
        pin_a_level_readback <= sync_a[2];
      end
      if (sync_b[1] == sync_b[2])
      begin
        pin_b_level_readback <= sync_b[2];
      end
    end
  end

  // Register image; reserved bits always read zero
  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[DRV_A_LSB +: 2] = pin_a_drive_type;
    stat_word[SEL_A_LSB +: 3] = pin_a_condition_select;
    stat_word[LVL_A_BIT] = pin_a_level_readback;
    stat_word[DRV_B_LSB +: 2] = pin_b_drive_type;
    stat_word[SEL_B_LSB +: 3] = pin_b_condition_select;
    stat_word[LVL_B_BIT] = pin_b_level_readback;
  end

  // Read data one clock after the strobe; unmapped reads zero
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      O_REG_RDATA <= 16'h0000;
    end
    else if (I_REG_RD)
    begin
      O_REG_RDATA <= (I_REG_ADDR == STAT_CTRL_OFFSET) ? stat_word
                                                      : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, one per pin
  // ----------------------------------------------------------------
  // Each pin re-decodes its field every clock
  bus_pin_cond #(.PIN_B(1'b0)) u_pin_a
  (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .i_sel(pin_a_condition_select),
    .i_drive(pin_a_drive_type),
    .i_suspend(I_SUSPEND),
    .i_bus_reset(I_BUS_RESET),
    .i_configured(I_CONFIGURED),
    .i_high_power(high_power),
    .o_pin(O_PIN_A),
    .o_pin_oe(O_PIN_A_OE)
  );

  bus_pin_cond #(.PIN_B(1'b1)) u_pin_b
  (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .i_sel(pin_b_condition_select),
    .i_drive(pin_b_drive_type),
    .i_suspend(I_SUSPEND),
    .i_bus_reset(I_BUS_RESET),
    .i_configured(I_CONFIGURED),
    .i_high_power(high_power),
    .o_pin(O_PIN_B),
    .o_pin_oe(O_PIN_B_OE)
  );

  // ----------------------------------------------------------------
  // Configuration memory control
  // ----------------------------------------------------------------
  assign otp_global_write_lock = otp_mem[OTP_HW_LOCK_CFG][LOCK_BIT];
  assign field_commit_bits_low = otp_mem[OTP_COMMIT_A];
  assign field_commit_bits_high = otp_mem[OTP_COMMIT_B];
  assign commit = {field_commit_bits_high, field_commit_bits_low};

  // Commit bit that guards the addressed location
  always_comb
  begin
    unique case (I_OTP_ADDR)
      OTP_VENDOR_LOW, OTP_VENDOR_HIGH: prog_field = 5'(CB_VENDOR);
      OTP_PRODUCT_LOW, OTP_PRODUCT_HIGH: prog_field = 5'(CB_PRODUCT);
      OTP_POWER_BUDGET: prog_field = 5'(CB_POWER);
      OTP_WAKE_ATTRS: prog_field = 5'(CB_ATTRS);
      OTP_RELEASE_HIGH, OTP_RELEASE_LOW: prog_field = 5'(CB_RELEASE);
      OTP_PURGE: prog_field = 5'(CB_PURGE);
      default: prog_field = 5'(CB_NONE);
    endcase
  end

  // Lock refuses everything; a committed field refuses change
  assign prog_ok = !otp_global_write_lock &&
                   (prog_field == 5'(CB_NONE) ||
                    !commit[prog_field[3:0]]);

  // Programming only ever sets bits; zeros never come back
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      // Volatile model: all cells start unprogrammed
      for (int i = 0; i < OTP_WORDS; i++)
      begin
        otp_mem[i] <= OTP_RESET;
      end
    end
    else if (I_OTP_PROG && prog_ok)
    begin
      // Byte-wide location
      otp_mem[I_OTP_ADDR] <= otp_mem[I_OTP_ADDR] | I_OTP_WDATA;
    end
  end

  // Read data and refusal flag, one clock after the strobe
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      O_OTP_RDATA <= OTP_RESET;
      O_OTP_REFUSED <= 1'b0;
    end
    else
    begin
      O_OTP_REFUSED <= I_OTP_PROG && !prog_ok;
      if (I_OTP_RD)
      begin
        O_OTP_RDATA <= otp_mem[I_OTP_ADDR];
      end
    end
  end

  // ----------------------------------------------------------------
  // Effective fields: zero until committed
  // ----------------------------------------------------------------
  // Trade-off: an uncommitted field is invisible even if written
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      O_VENDOR_CODE <= 16'h0000;
      O_PRODUCT_CODE <= 16'h0000;
    end
    else
    begin
      O_VENDOR_CODE <= commit[CB_VENDOR] ?
        {otp_mem[OTP_VENDOR_HIGH], otp_mem[OTP_VENDOR_LOW]} : 16'h0000;
      O_PRODUCT_CODE <= commit[CB_PRODUCT] ?
        {otp_mem[OTP_PRODUCT_HIGH], otp_mem[OTP_PRODUCT_LOW]} : 16'h0000;
    end
  end

  // Power class feeds the select-010 and select-110 decode
  assign eff_power = commit[CB_POWER] ? otp_mem[OTP_POWER_BUDGET]
                                      : 8'h00;
  assign high_power = eff_power > LOW_POWER_MAX;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      O_HIGH_POWER <= 1'b0;
    end
    else
    begin
      O_HIGH_POWER <= high_power;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);

  // Pin a level expected for the present field and bus state
  logic exp_a;
  always_comb
  begin
    unique case (pin_a_condition_select)
      3'h0: exp_a = ~(I_SUSPEND | I_BUS_RESET);
      3'h1: exp_a = I_SUSPEND;
      3'h2: exp_a = I_SUSPEND | (high_power & ~I_CONFIGURED);
      3'h3: exp_a = I_BUS_RESET;
      3'h4: exp_a = ~(I_SUSPEND | I_BUS_RESET);
      3'h5: exp_a = ~I_SUSPEND;
      3'h6: exp_a = ~(I_SUSPEND | (high_power & ~I_CONFIGURED));
      default: exp_a = ~I_BUS_RESET;
    endcase
  end

  property p_drive_reset;
    $rose(I_NRST) |-> pin_a_drive_type == DRV_RESET &&
                      pin_b_drive_type == DRV_RESET;
  endproperty
  a_drive_reset: assert property (@(posedge I_SYS_CLK) p_drive_reset)
    else $error("drive fields not 0x2 after reset");

  property p_pin_b_od;
    pin_b_drive_type == DRV_OPEN_DRAIN ##1
      pin_b_drive_type == DRV_OPEN_DRAIN |-> O_PIN_B == 1'b0;
  endproperty
  a_pin_b_od: assert property (p_pin_b_od)
    else $error("open-drain pin b drives high");

  property p_pin_a_pp;
    pin_a_drive_type == DRV_PUSH_PULL |=> O_PIN_A_OE;
  endproperty
  a_pin_a_pp: assert property (p_pin_a_pp)
    else $error("push-pull pin a not driven");

  property p_pin_a_level;
    pin_a_drive_type == DRV_PUSH_PULL |=> O_PIN_A == $past(exp_a);
  endproperty
  a_pin_a_level: assert property (p_pin_a_level)
    else $error("pin a level wrong for select code");

  property p_sel_suspend;
    pin_a_condition_select == 3'h1 &&
      pin_a_drive_type == DRV_PUSH_PULL && I_SUSPEND |=> O_PIN_A;
  endproperty
  a_sel_suspend: assert property (p_sel_suspend)
    else $error("select 001 not high in suspend");

  property p_sel_reset_low;
    pin_a_condition_select == 3'h7 && I_BUS_RESET &&
      pin_a_drive_type == DRV_PUSH_PULL |=> !O_PIN_A;
  endproperty
  a_sel_reset_low: assert property (p_sel_reset_low)
    else $error("select 111 not low on reset");

  property p_readback_a;
    // Three sync edges, the agreeing edge, then one to show: five samples
    (I_PIN_A == 1'b1) [*5] |-> stat_word[LVL_A_BIT];
  endproperty
  a_readback_a: assert property (p_readback_a)
    else $error("bit 5 misses steady pin a level");

  property p_readback_b;
    (I_PIN_B == 1'b0) [*5] |-> !stat_word[LVL_B_BIT];
  endproperty
  a_readback_b: assert property (p_readback_b)
    else $error("bit 13 misses steady pin b level");

  property p_reserved_zero;
    I_REG_RD |=> O_REG_RDATA[7:6] == 2'h0 && O_REG_RDATA[15:14] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_lock_refuse;
    I_OTP_PROG && otp_global_write_lock |=> O_OTP_REFUSED ##0
      otp_mem[$past(I_OTP_ADDR)] == $past(otp_mem[I_OTP_ADDR]);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("programming accepted under lock");

  property p_commit_freeze;
    I_OTP_PROG && commit[CB_VENDOR] &&
      I_OTP_ADDR == OTP_VENDOR_LOW |=> O_OTP_REFUSED;
  endproperty
  a_commit_freeze: assert property (p_commit_freeze)
    else $error("committed field accepted a change");

  property p_bits_stick;
    I_OTP_PROG && prog_ok |=>
      (otp_mem[$past(I_OTP_ADDR)] & $past(I_OTP_WDATA)) ==
        $past(I_OTP_WDATA);
  endproperty
  a_bits_stick: assert property (p_bits_stick)
    else $error("programmed ones not held");

  c_lock: cover property (I_OTP_PROG && otp_global_write_lock);
  c_od_release: cover property (pin_a_drive_type == DRV_OPEN_DRAIN
                                ##2 !O_PIN_A_OE);
  c_hp_unconf: cover property (pin_a_condition_select == 3'h2 &&
                               high_power && !I_CONFIGURED);

endmodule : bus_pin_otp_top

// >>> status_pin_monitor.sv
// Board-side model: pull-ups on both status pins resolve the pad level
module status_pin_monitor
(
  // Pin drive from the device
  input wire logic i_pin_a,
  input wire logic i_pin_a_oe,
  input wire logic i_pin_b,
  input wire logic i_pin_b_oe,
  // Resolved pad levels
  output logic o_pad_a,
  output logic o_pad_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released or open-drain high: the pull-up wins, never the old value
  assign o_pad_a = i_pin_a_oe ? i_pin_a : 1'b1;
  assign o_pad_b = i_pin_b_oe ? i_pin_b : 1'b1;
endmodule : status_pin_monitor

// >>> tb_top.sv
// Self-checking bench for the status pins and configuration memory
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bus_pin_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0, nrst = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, otp_prog = 1'b0, otp_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, vendor_code, product_code;
  logic [4:0] otp_addr = 5'h00;
  logic [7:0] otp_wdata = 8'h00, otp_rdata;
  logic suspend = 1'b0, bus_reset = 1'b0, configured = 1'b1;
  logic otp_refused, high_power, pad_a, pad_b;
  logic pin_a, pin_a_oe, pin_b, pin_b_oe;
  int miscompares = 0, num_checks = 0;
  // 10 MHz core clock
  always #50 sys_clk = ~sys_clk;
  bus_pin_otp_top u_dut
  (
    .I_SYS_CLK(sys_clk), .I_NRST(nrst),
    .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .I_REG_ADDR(reg_addr),
    .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata),
    .I_OTP_PROG(otp_prog), .I_OTP_RD(otp_rd), .I_OTP_ADDR(otp_addr),
    .I_OTP_WDATA(otp_wdata), .O_OTP_RDATA(otp_rdata),
    .O_OTP_REFUSED(otp_refused), .I_SUSPEND(suspend),
    .I_BUS_RESET(bus_reset), .I_CONFIGURED(configured),
    .I_PIN_A(pad_a), .O_PIN_A(pin_a), .O_PIN_A_OE(pin_a_oe),
    .I_PIN_B(pad_b), .O_PIN_B(pin_b), .O_PIN_B_OE(pin_b_oe),
    .O_VENDOR_CODE(vendor_code), .O_PRODUCT_CODE(product_code),
    .O_HIGH_POWER(high_power)
  );
  status_pin_monitor u_mon
  (
    .i_pin_a(pin_a), .i_pin_a_oe(pin_a_oe), .i_pin_b(pin_b),
    .i_pin_b_oe(pin_b_oe), .o_pad_a(pad_a), .o_pad_b(pad_b)
  );
  // ------------------------------------------------------------
  // Compare and bus tasks (entered at a falling edge)
  // ------------------------------------------------------------
  task automatic check_word(input string what, input logic [15:0] e,
                            input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check_word
  task automatic check_bit(input string what, input logic e, input logic g);
    check_word(what, {15'h0, e}, {15'h0, g});
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    // Idle edge so a following call never re-raises the strobe at once
    cyc(1);
  endtask : reg_write
  // Read data lands at the read edge, so it is settled one half later
  task automatic reg_read(input logic [11:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    cyc(1);
  endtask : reg_read
  task automatic otp_write(input logic [4:0] a, input logic [7:0] d,
                           input logic refused);
    otp_addr = a;
    otp_wdata = d;
    otp_prog = 1'b1;
    cyc(1);
    otp_prog = 1'b0;
    check_bit("refused", refused, otp_refused);
    cyc(1);
  endtask : otp_write
  task automatic otp_check(input logic [4:0] a, input logic [7:0] e);
    otp_addr = a;
    otp_rd = 1'b1;
    cyc(1);
    otp_rd = 1'b0;
    check_word("otp byte", {8'h00, e}, {8'h00, otp_rdata});
    cyc(1);
  endtask : otp_check
  // Expected pin level: asserted condition turned to the pin polarity
  function automatic logic lvl(input logic [2:0] s, input logic hi,
                               input logic sp, br, cf, hp);
    logic a;
    case (s[1:0])
      2'b00: a = sp | br;
      2'b01: a = sp;
      2'b10: a = sp | (hp & ~cf);
      default: a = br;
    endcase
    return a ~^ hi;
  endfunction : lvl
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_reset();
    logic [15:0] d;
    reg_read(STAT_CTRL_OFFSET, d);
    check_word("status reset", 16'h0222, d);
    reg_read(12'h260, d);
    check_word("unmapped", 16'h0000, d);
    otp_check(OTP_VENDOR_LOW, 8'h00);
  endtask : sc_reset
  // Every select code with every suspend / bus reset mix, push-pull
  task automatic sc_select();
    logic [2:0] s;
    logic [15:0] d;
    logic la, lb;
    for (int i = 0; i < 8; i++)
    begin
      s = i[2:0];
      reg_write(STAT_CTRL_OFFSET, {3'h1, s, 5'h10, s, 2'h2});
      for (int k = 0; k < 4; k++)
      begin
        suspend = k[0];
        bus_reset = k[1];
        la = lvl(s, s != 3'h0 && s < 3'h4, k[0], k[1], 1'b1, 1'b0);
        lb = lvl(s, s <= 3'h4, k[0], k[1], 1'b1, 1'b0);
        cyc(1);
        check_bit("pin a", la, pin_a);
        check_bit("pin b", lb, pin_b);
        cyc(5);
        reg_read(STAT_CTRL_OFFSET, d);
        check_word("readback", {2'h0, lb, s, 4'h8, la, s, 2'h2}, d);
      end
    end
    suspend = 1'b0;
    bus_reset = 1'b0;
  endtask : sc_select
  // All four drive codes on both pins, level low and high
  task automatic sc_drive();
    logic [1:0] c;
    logic [15:0] d;
    logic oe, o;
    for (int i = 0; i < 8; i++)
    begin
      c = i[1:0];
      suspend = i[2];
      reg_write(STAT_CTRL_OFFSET, {6'h01, c, 6'h01, c});
      oe = (c == 2'h2) ? 1'b1 : (c == 2'h1) ? ~i[2] : 1'b0;
      o = (c == 2'h2) ? i[2] : 1'b0;
      cyc(1);
      check_word("drive", {12'h000, o, oe, o, oe},
                 {12'h000, pin_a, pin_a_oe, pin_b, pin_b_oe});
      cyc(5);
      reg_read(STAT_CTRL_OFFSET, d);
      check_bit("pad a", oe ? o : 1'b1, d[LVL_A_BIT]);
      check_bit("pad b", oe ? o : 1'b1, d[LVL_B_BIT]);
    end
    suspend = 1'b0;
  endtask : sc_drive
  // Bytes, commit guard, power class and the unconfigured condition
  task automatic sc_otp();
    otp_write(OTP_OVR_FIRST, 8'h0f, 1'b0);
    otp_write(OTP_OVR_FIRST, 8'hf0, 1'b0);
    otp_check(OTP_OVR_FIRST, 8'hff);
    otp_write(OTP_VENDOR_LOW, 8'hab, 1'b0);
    otp_write(OTP_VENDOR_HIGH, 8'hcd, 1'b0);
    otp_write(OTP_POWER_BUDGET, 8'h33, 1'b0);
    cyc(3);
    check_word("vendor early", 16'h0000, vendor_code);
    otp_write(OTP_COMMIT_B, 8'h05, 1'b0);
    cyc(3);
    check_word("vendor", 16'hcdab, vendor_code);
    check_word("product", 16'h0000, product_code);
    check_bit("high power", 1'b1, high_power);
    otp_write(OTP_VENDOR_LOW, 8'hff, 1'b1);
    otp_check(OTP_VENDOR_LOW, 8'hab);
    for (int i = 0; i < 4; i++)
    begin
      configured = i[0];
      reg_write(STAT_CTRL_OFFSET, {8'h02, 3'h0, i[1], 2'h2, 2'h2});
      cyc(1);
      check_bit("pin a hp", i[1] ^ ~i[0], pin_a);
    end
    configured = 1'b1;
  endtask : sc_otp
  // Lock refuses everything that follows at once
  task automatic sc_lock();
    otp_write(OTP_HW_LOCK_CFG, 8'h40, 1'b0);
    otp_write(5'h08, 8'h01, 1'b1);
    otp_check(5'h08, 8'h00);
  endtask : sc_lock
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    cyc(16);
    nrst = 1'b1;
    cyc(6);
    sc_reset();
    sc_select();
    sc_drive();
    sc_otp();
    sc_lock();
    print_verdict();
  end
endmodule : tb_top
